// ===== pmsw_ctrl.sv
// Purpose: Program memory self-write controller top
// Assumes: Flash macro answers strobes on this clock, data combinational
// Notes: Config word input is already stable on this clock
`timescale 1ns/1ns
module pmsw_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire logic [pmsw_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pmsw_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pmsw_pkg::DATA_W-1:0] reg_rdata,
	output logic irq,
	input wire logic [pmsw_pkg::CFG_W-1:0] cfg_word_two,
	input wire logic [pmsw_pkg::PM_ADDR_W-1:0] pm_addr,
	input wire logic [pmsw_pkg::PM_DATA_W-1:0] pm_wdata,
	input wire logic [pmsw_pkg::PM_DATA_W-1:0] flash_rdata,
	input wire logic flash_done,
	output logic [pmsw_pkg::PM_ADDR_W-1:0] flash_addr,
	output logic [pmsw_pkg::PM_DATA_W-1:0] flash_wdata,
	output logic flash_space,
	output logic flash_rd_strb,
	output logic flash_latch_strb,
	output logic flash_prog_strb,
	output logic flash_erase_strb
);
	pmsw_pkg::pmsw_state_t state_r;
	pmsw_pkg::pmsw_state_t state_nxt;
	logic space_r;
	logic latch_only_r;
	logic erase_r;
	logic err_r;
	logic en_r;
	logic wr_r;
	logic rd_r;
	logic [pmsw_pkg::DATA_W-1:0] rdata_r;
	logic [pmsw_pkg::PM_DATA_W-1:0] rbuf_r;
	logic [pmsw_pkg::PM_ADDR_W-1:0] addr_r;
	logic [pmsw_pkg::PM_DATA_W-1:0] wdata_r;
	logic space_out_r;
	logic rd_strb_r;
	logic latch_strb_r;
	logic prog_strb_r;
	logic erase_strb_r;
	logic ctrl_we;
	logic wr_set;
	logic rd_set;
	logic idle;
	logic prot_hit;
	logic refuse;
	logic eff_latch_only;
	logic finish_ok;
	logic [pmsw_pkg::CTRL_W-1:0] ctrl_view;
	logic [pmsw_pkg::DATA_W-1:0] rd_mux;

	pmsw_irq_if irq_bus ();

	pmsw_irq u_irq (
		.clk(clk),
		.reset(reset),
		.bus(irq_bus.unit)
	);

	pmsw_wprot u_wprot (
		.wp_field(cfg_word_two[pmsw_pkg::WP_LSB +: pmsw_pkg::WP_W]),
		.space_sel(space_r),
		.addr(addr_r),
		.protected_hit(prot_hit)
	);

	assign idle = (state_r == pmsw_pkg::st_idle);
	assign ctrl_we = reg_wr && (reg_addr == pmsw_pkg::CTRL_OFS);
	// [RQ7] set-only write start
	assign wr_set = ctrl_we && reg_wdata[pmsw_pkg::B_WR] && idle && ~wr_r;
	// [RQ8] set-only read start
	assign rd_set = ctrl_we && reg_wdata[pmsw_pkg::B_RD] && idle && ~rd_r &&
		~wr_set;
	// [RQ6] enable interlock
	assign refuse = ~en_r || prot_hit;
	// [RQ3] erase overrides latch-only
	assign eff_latch_only = latch_only_r && ~erase_r;
	assign finish_ok = ((state_r == pmsw_pkg::st_latch) && eff_latch_only) ||
		((state_r == pmsw_pkg::st_wait) && flash_done);

	// Sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			pmsw_pkg::st_idle: begin
				if (wr_set) begin
					state_nxt = pmsw_pkg::st_check;
				end else if (rd_set) begin
					state_nxt = pmsw_pkg::st_read;
				end
			end
			pmsw_pkg::st_check: begin
				// [RQ10] refused command ends quietly
				if (refuse) begin
					state_nxt = pmsw_pkg::st_idle;
				end else if (erase_r) begin
					state_nxt = pmsw_pkg::st_erase;
				end else begin
					state_nxt = pmsw_pkg::st_latch;
				end
			end
			pmsw_pkg::st_erase: state_nxt = pmsw_pkg::st_wait;
			pmsw_pkg::st_latch: begin
				// [RQ2] latch only or latch then program
				if (eff_latch_only) begin
					state_nxt = pmsw_pkg::st_idle;
				end else begin
					state_nxt = pmsw_pkg::st_prog;
				end
			end
			pmsw_pkg::st_prog: state_nxt = pmsw_pkg::st_wait;
			pmsw_pkg::st_wait: begin
				if (flash_done) begin
					state_nxt = pmsw_pkg::st_idle;
				end
			end
			pmsw_pkg::st_read: state_nxt = pmsw_pkg::st_idle;
			default: state_nxt = pmsw_pkg::st_idle;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= pmsw_pkg::st_idle;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Mode bits frozen while busy so a running operation keeps its target
	always_ff @(posedge clk) begin
		if (reset) begin
			space_r <= 1'b0;
			latch_only_r <= 1'b0;
			en_r <= 1'b0;
		end else if (ctrl_we && idle) begin
			space_r <= reg_wdata[pmsw_pkg::B_SPACE];
			latch_only_r <= reg_wdata[pmsw_pkg::B_LATCH];
			en_r <= reg_wdata[pmsw_pkg::B_EN];
		end
	end

	// [RQ4] erase select cleared on completion
	always_ff @(posedge clk) begin
		if (reset) begin
			erase_r <= 1'b0;
		end else if ((state_r == pmsw_pkg::st_wait) && flash_done) begin
			erase_r <= 1'b0;
		end else if (ctrl_we && idle) begin
			erase_r <= reg_wdata[pmsw_pkg::B_ERASE];
		end
	end

	// [RQ5] error set on start, cleared on normal end
	always_ff @(posedge clk) begin
		if (reset) begin
			err_r <= 1'b0;
		end else if (wr_set) begin
			err_r <= 1'b1;
		end else if (finish_ok) begin
			err_r <= 1'b0;
		end else if (ctrl_we) begin
			err_r <= reg_wdata[pmsw_pkg::B_ERR];
		end
	end

	// [RQ7] hardware clears write control
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_r <= 1'b0;
		end else if (wr_set) begin
			wr_r <= 1'b1;
		end else if (finish_ok ||
			((state_r == pmsw_pkg::st_check) && refuse)) begin
			wr_r <= 1'b0;
		end
	end

	// [RQ8] one-cycle read and self clear
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_r <= 1'b0;
			rbuf_r <= '0;
		end else if (rd_set) begin
			rd_r <= 1'b1;
		end else if (state_r == pmsw_pkg::st_read) begin
			rd_r <= 1'b0;
			rbuf_r <= flash_rdata;
		end
	end

	// [RQ1] target space and address held for the operation
	always_ff @(posedge clk) begin
		if (reset) begin
			addr_r <= '0;
			wdata_r <= '0;
			space_out_r <= 1'b0;
		end else if (wr_set || rd_set) begin
			addr_r <= pm_addr;
			wdata_r <= pm_wdata;
			// Same write may set space and start, so take the new value
			space_out_r <= reg_wdata[pmsw_pkg::B_SPACE];
		end
	end

	// Strobes registered from next state to line up with the state
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_strb_r <= 1'b0;
			latch_strb_r <= 1'b0;
			prog_strb_r <= 1'b0;
			erase_strb_r <= 1'b0;
		end else begin
			rd_strb_r <= (state_nxt == pmsw_pkg::st_read);
			latch_strb_r <= (state_nxt == pmsw_pkg::st_latch);
			prog_strb_r <= (state_nxt == pmsw_pkg::st_prog);
			erase_strb_r <= (state_nxt == pmsw_pkg::st_erase);
		end
	end

	// Events toward the interrupt unit
	always_comb begin
		irq_bus.evt = '0;
		irq_bus.evt[pmsw_pkg::EV_DONE] = finish_ok;
		irq_bus.evt[pmsw_pkg::EV_FAIL] = (state_r == pmsw_pkg::st_check) &&
			refuse;
		irq_bus.evt[pmsw_pkg::EV_READ] = (state_r == pmsw_pkg::st_read);
		irq_bus.wdata = reg_wdata[pmsw_pkg::EV_W-1:0];
		irq_bus.stat_we = reg_wr && (reg_addr == pmsw_pkg::IRQ_STAT_OFS);
		irq_bus.mask_we = reg_wr && (reg_addr == pmsw_pkg::IRQ_MASK_OFS);
	end

	// Register read path, unmapped addresses read zero
	always_comb begin
		ctrl_view = {1'b1, space_r, latch_only_r, erase_r, err_r, en_r,
			wr_r, rd_r};
		rd_mux = pmsw_pkg::RD_ZERO;
		unique case (reg_addr)
			pmsw_pkg::CTRL_OFS: rd_mux = {8'h00, ctrl_view};
			pmsw_pkg::IRQ_STAT_OFS: rd_mux = {13'h0000, irq_bus.status};
			pmsw_pkg::IRQ_MASK_OFS: rd_mux = {13'h0000, irq_bus.mask};
			pmsw_pkg::RDATA_OFS: rd_mux = {2'h0, rbuf_r};
			pmsw_pkg::CFG2_OFS: rd_mux = {2'h0, cfg_word_two};
			default: rd_mux = pmsw_pkg::RD_ZERO;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_r <= pmsw_pkg::RD_ZERO;
		end else if (reg_rd) begin
			rdata_r <= rd_mux;
		end else begin
			rdata_r <= pmsw_pkg::RD_ZERO;
		end
	end

	assign reg_rdata = rdata_r;
	assign irq = irq_bus.irq;
	assign flash_addr = addr_r;
	assign flash_wdata = wdata_r;
	assign flash_space = space_out_r;
	assign flash_rd_strb = rd_strb_r;
	assign flash_latch_strb = latch_strb_r;
	assign flash_prog_strb = prog_strb_r;
	assign flash_erase_strb = erase_strb_r;

	// [RQ5] error flag rises with write control
	a_start_sets_err: assert property (@(posedge clk) disable iff (reset)
		wr_set |=> (err_r && wr_r && state_r == pmsw_pkg::st_check))
		else $error("start did not raise error flag"); // [RQ5]

	// [RQ5] normal finish clears error
	a_finish_clears_err: assert property (@(posedge clk) disable iff (reset)
		(finish_ok && !wr_set) |=> (!err_r && !wr_r))
		else $error("normal finish left error or write bit"); // [RQ5]

	// [RQ6] disabled command never strobes Flash
	a_disabled_inhibit: assert property (@(posedge clk) disable iff (reset)
		(state_r == pmsw_pkg::st_check && !en_r) |=>
		(!flash_prog_strb && !flash_erase_strb && !flash_latch_strb && err_r
		&& !wr_r))
		else $error("disabled command reached Flash"); // [RQ6]

	// [RQ10] protected command leaves Flash alone
	a_protect_block: assert property (@(posedge clk) disable iff (reset)
		(state_r == pmsw_pkg::st_check && prot_hit) |=>
		(idle && !flash_latch_strb) ##1 (!flash_prog_strb && err_r))
		else $error("protected address was written"); // [RQ10]

	// [RQ2] latch then program when not latch-only
	a_latch_then_prog: assert property (@(posedge clk) disable iff (reset)
		(state_r == pmsw_pkg::st_latch && !latch_only_r) |=>
		flash_prog_strb)
		else $error("program did not follow latch"); // [RQ2]

	// [RQ2] latch-only stops after the latch
	a_latch_only_end: assert property (@(posedge clk) disable iff (reset)
		(state_r == pmsw_pkg::st_latch && latch_only_r) |=>
		(idle && !flash_prog_strb))
		else $error("latch-only command programmed Flash"); // [RQ2]

	// [RQ3] erase path ignores latch-only
	a_erase_path: assert property (@(posedge clk) disable iff (reset)
		(state_r == pmsw_pkg::st_check && !refuse && erase_r) |=>
		(flash_erase_strb && !flash_latch_strb) ##1 !flash_prog_strb)
		else $error("erase took the write path"); // [RQ3]

	// [RQ4] erase select self-clears at completion
	a_erase_self_clear: assert property (@(posedge clk) disable iff (reset)
		(state_r == pmsw_pkg::st_wait && flash_done && erase_r) |=>
		(!erase_r && !wr_r && idle))
		else $error("erase select not cleared"); // [RQ4]

	// [RQ8] read strobe one cycle, bit clears after
	a_read_one_cycle: assert property (@(posedge clk) disable iff (reset)
		rd_set |=> (flash_rd_strb && rd_r) ##1 (!flash_rd_strb && !rd_r))
		else $error("read did not finish in one cycle"); // [RQ8]

	// [RQ7] write bit holds until hardware ends it
	a_wr_holds: assert property (@(posedge clk) disable iff (reset)
		(wr_r && state_r == pmsw_pkg::st_prog) |=> wr_r)
		else $error("write bit dropped mid operation"); // [RQ7]

	// [RQ1] latch, erase and read strobes carry the selected space
	a_space_route: assert property (@(posedge clk) disable iff (reset)
		(flash_latch_strb || flash_erase_strb || flash_rd_strb) |->
		(flash_space == space_r))
		else $error("access went to the wrong space"); // [RQ1]
endmodule : pmsw_ctrl

// ===== pmsw_irq.sv
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Events are one-cycle pulses on the core clock
// Notes: Write one to clear; a new event beats the clear
`timescale 1ns/1ns
module pmsw_irq (
	input wire logic clk,
	input wire logic reset,
	pmsw_irq_if.unit bus
);
	logic [pmsw_pkg::EV_W-1:0] stat_r;
	logic [pmsw_pkg::EV_W-1:0] stat_nxt;
	logic [pmsw_pkg::EV_W-1:0] mask_r;
	logic [pmsw_pkg::EV_W-1:0] mask_nxt;
	logic irq_r;

	genvar i;
	generate
		for (i = 0; i < pmsw_pkg::EV_W; i++) begin : g_bit
			// Set wins so no event is lost
			assign stat_nxt[i] = bus.evt[i] | (stat_r[i] &
				~(bus.stat_we & bus.wdata[i]));
		end
	endgenerate
	assign mask_nxt = bus.mask_we ? bus.wdata : mask_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			stat_r <= pmsw_pkg::EV_RST;
			mask_r <= pmsw_pkg::EV_RST;
			irq_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			irq_r <= |(stat_nxt & mask_nxt);
		end
	end

	assign bus.status = stat_r;
	assign bus.mask = mask_r;
	assign bus.irq = irq_r;
endmodule : pmsw_irq

// ===== pmsw_irq_if.sv
// Purpose: Carries events and interrupt register traffic
// Assumes: Core and interrupt unit share one clock
// Notes: Core drives events and write strobes, unit returns state
`timescale 1ns/1ns
interface pmsw_irq_if;
	logic [pmsw_pkg::EV_W-1:0] evt;
	logic [pmsw_pkg::EV_W-1:0] wdata;
	logic stat_we;
	logic mask_we;
	logic [pmsw_pkg::EV_W-1:0] status;
	logic [pmsw_pkg::EV_W-1:0] mask;
	logic irq;
	modport core (output evt, wdata, stat_we, mask_we,
		input status, mask, irq);
	modport unit (input evt, wdata, stat_we, mask_we,
		output status, mask, irq);
endinterface : pmsw_irq_if

// ===== pmsw_pkg.sv
// Purpose: Shared constants and types of the program memory self-write block
// Assumes: Single 25 MHz clock, synchronous active-high reset
// Notes: Offsets are word-free byte addresses on a plain register port
// How it works
// [RQ1] Space select 1 routes accesses to configuration and identifier space
// [RQ2] Latch-only loads one write latch; otherwise latch then program all
// [RQ3] Latch-only is ignored while erase select is set
// [RQ4] Erase select erases on next write command, cleared on completion
// [RQ5] Starting program or erase sets the error flag; normal end clears it
// [RQ6] Program and erase only happen while program enable is set
// [RQ7] Write control is set-only by software, cleared by hardware at end
// [RQ8] Read control starts a one-cycle read, then clears itself
// [RQ9] Two-bit protect field picks the protected low address range
// [RQ10] Disabled or protected write leaves Flash unchanged and keeps error
package pmsw_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned PM_ADDR_W = 15;
	localparam int unsigned PM_DATA_W = 14;
	localparam int unsigned CFG_W = 14;
	localparam int unsigned EV_W = 3;

	localparam logic [ADDR_W-1:0] CTRL_OFS = 16'h0000;
	localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 16'h0004;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 16'h0008;
	localparam logic [ADDR_W-1:0] RDATA_OFS = 16'h000c;
	localparam logic [ADDR_W-1:0] CFG2_OFS = 16'h8008;

	localparam int unsigned B_RD = 0;
	localparam int unsigned B_WR = 1;
	localparam int unsigned B_EN = 2;
	localparam int unsigned B_ERR = 3;
	localparam int unsigned B_ERASE = 4;
	localparam int unsigned B_LATCH = 5;
	localparam int unsigned B_SPACE = 6;
	localparam int unsigned B_UNIMP = 7;
	localparam int unsigned CTRL_W = 8;

	localparam int unsigned EV_DONE = 0;
	localparam int unsigned EV_FAIL = 1;
	localparam int unsigned EV_READ = 2;

	localparam int unsigned WP_LSB = 0;
	localparam int unsigned WP_W = 2;
	localparam logic [WP_W-1:0] WP_NONE = 2'h3;
	localparam logic [WP_W-1:0] WP_SMALL = 2'h2;
	localparam logic [WP_W-1:0] WP_HALF = 2'h1;
	localparam logic [11:0] WP_SMALL_TOP = 12'h01ff;
	localparam logic [11:0] WP_HALF_TOP = 12'h07ff;
	localparam logic [11:0] WP_ALL_TOP = 12'h0fff;

	localparam logic [DATA_W-1:0] RD_ZERO = 16'h0000;
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
	localparam logic [EV_W-1:0] EV_RST = 3'h0;

	typedef enum logic [2:0] {
		st_idle,
		st_check,
		st_erase,
		st_latch,
		st_prog,
		st_wait,
		st_read
	} pmsw_state_t;
endpackage : pmsw_pkg

// ===== pmsw_wprot.sv
// Purpose: Write protection decode of the self-write address
// Assumes: Program space spans 000h to FFFh
// Notes: Configuration space is never range protected here
`timescale 1ns/1ns
module pmsw_wprot (
	input wire logic [pmsw_pkg::WP_W-1:0] wp_field,
	input wire logic space_sel,
	input wire logic [pmsw_pkg::PM_ADDR_W-1:0] addr,
	output logic protected_hit
);
	localparam int unsigned PM_ADDR_HI = pmsw_pkg::PM_ADDR_W - 1;
	logic [11:0] top;

	// [RQ9] range select decode
	always_comb begin
		top = pmsw_pkg::WP_ALL_TOP;
		unique case (wp_field)
			pmsw_pkg::WP_SMALL: top = pmsw_pkg::WP_SMALL_TOP;
			pmsw_pkg::WP_HALF: top = pmsw_pkg::WP_HALF_TOP;
			default: top = pmsw_pkg::WP_ALL_TOP;
		endcase
		protected_hit = ~space_sel && (wp_field != pmsw_pkg::WP_NONE) &&
			(addr[PM_ADDR_HI:12] == '0) && (addr[11:0] <= top);
	end
endmodule : pmsw_wprot

// ===== program_memory_self_write_ctrl_test.sv
// Purpose: Self-checking bench of the program memory self-write block
// Assumes: Bench plays the Flash side and answers done promptly
// Notes: Outputs are sampled one ns after the rising edge
`timescale 1ns/1ns
module program_memory_self_write_ctrl_test;
	logic clk;
	logic reset;
	logic [15:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_rdata;
	logic irq;
	logic [13:0] cfg_word_two;
	logic [14:0] pm_addr;
	logic [13:0] pm_wdata;
	logic [13:0] flash_rdata;
	logic flash_done;
	logic [14:0] flash_addr;
	logic [13:0] flash_wdata;
	logic flash_space;
	logic flash_rd_strb, flash_latch_strb, flash_prog_strb, flash_erase_strb;
	int failures;
	int checked;
	int cycles;

	pmsw_ctrl DUT (
		.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .cfg_word_two(cfg_word_two),
		.pm_addr(pm_addr), .pm_wdata(pm_wdata), .flash_rdata(flash_rdata),
		.flash_done(flash_done), .flash_addr(flash_addr),
		.flash_wdata(flash_wdata), .flash_space(flash_space),
		.flash_rd_strb(flash_rd_strb), .flash_latch_strb(flash_latch_strb),
		.flash_prog_strb(flash_prog_strb), .flash_erase_strb(flash_erase_strb)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	// Ceiling well above the several hundred cycles the tests need
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			$display("ERROR at %0t: run did not finish", $time);
			end_of_test();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd_reg

	// Expected strobes as {error, erase, program, latch}
	task automatic run_cmd(input logic [7:0] c, input logic [14:0] a,
		input logic [3:0] exp);
		logic [3:0] seen;
		logic [15:0] d;
		logic [13:0] wd;
		seen = 4'h0;
		wd = a[13:0] ^ 14'h1555;
		pm_addr <= a;
		pm_wdata <= wd;
		wr_reg(pmsw_pkg::CTRL_OFS, {8'h00, c});
		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			#1;
			seen = seen | {1'b0, flash_erase_strb, flash_prog_strb,
				flash_latch_strb};
			if (flash_prog_strb === 1'b1 || flash_erase_strb === 1'b1) begin
				rd_reg(pmsw_pkg::CTRL_OFS, d);
				check(d & 16'h000a, 16'h000a);
				@(posedge clk);
				flash_done <= 1'b1;
				@(posedge clk);
				flash_done <= 1'b0;
			end
		end
		rd_reg(pmsw_pkg::CTRL_OFS, d);
		seen[3] = d[3];
		check({12'h000, seen}, {12'h000, exp});
		check(d & 16'h0013, 16'h0000);
		if (exp[2:0] != 3'h0) begin
			check({1'b0, flash_addr}, {1'b0, a});
			check({15'h0000, flash_space}, {15'h0000, c[6]});
		end
		if (exp[0]) begin
			check({2'h0, flash_wdata}, {2'h0, wd});
		end
	endtask : run_cmd

	task automatic t_reset();
		logic [15:0] d;
		rd_reg(pmsw_pkg::CTRL_OFS, d);
		check(d, 16'h0080);
		rd_reg(pmsw_pkg::IRQ_STAT_OFS, d);
		check(d, 16'h0000);
		rd_reg(16'h0010, d);
		check(d, 16'h0000);
		rd_reg(pmsw_pkg::CFG2_OFS, d);
		check(d, 16'h3fff);
		check({15'h0000, irq}, 16'h0000);
		$display("reset test done");
	endtask : t_reset

	task automatic t_read();
		logic [15:0] d;
		flash_rdata <= 14'h2a5b;
		pm_addr <= 15'h0123;
		wr_reg(pmsw_pkg::CTRL_OFS, 16'h0041);
		#1;
		check({15'h0000, flash_rd_strb}, 16'h0001);
		check({15'h0000, flash_space}, 16'h0001);
		@(posedge clk);
		// Data must be held after the strobe cycle
		flash_rdata <= 14'h0000;
		#1;
		check({15'h0000, flash_rd_strb}, 16'h0000);
		rd_reg(pmsw_pkg::CTRL_OFS, d);
		check(d, 16'h00c0);
		rd_reg(pmsw_pkg::RDATA_OFS, d);
		check(d, 16'h2a5b);
		check({1'b0, flash_addr}, 16'h0123);
		$display("read test done");
	endtask : t_read

	task automatic t_modes();
		run_cmd(8'h02, 15'h0040, 4'h8);
		run_cmd(8'h26, 15'h0041, 4'h1);
		run_cmd(8'h06, 15'h0042, 4'h3);
		run_cmd(8'h36, 15'h0080, 4'h4);
		run_cmd(8'h16, 15'h0080, 4'h4);
		$display("mode test done");
	endtask : t_modes

	task automatic t_protect();
		logic [14:0] adr [5] = '{15'h01ff, 15'h0200, 15'h07ff, 15'h0800,
			15'h0fff};
		logic [14:0] top [3] = '{15'h0fff, 15'h07ff, 15'h01ff};
		logic prot;
		for (int w = 0; w < 4; w++) begin
			cfg_word_two <= {12'hfff, w[1:0]};
			for (int k = 0; k < 5; k++) begin
				prot = (w < 3) && (adr[k] <= top[w % 3]);
				run_cmd(8'h06, adr[k], prot ? 4'h8 : 4'h3);
			end
		end
		// Configuration space lies outside the protected range
		cfg_word_two <= 14'h3ffc;
		run_cmd(8'h46, 15'h0000, 4'h3);
		cfg_word_two <= 14'h3fff;
		$display("protect test done");
	endtask : t_protect

	task automatic t_irq();
		logic [15:0] d;
		wr_reg(pmsw_pkg::IRQ_STAT_OFS, 16'h0007);
		wr_reg(pmsw_pkg::IRQ_MASK_OFS, 16'h0002);
		rd_reg(pmsw_pkg::IRQ_MASK_OFS, d);
		check(d, 16'h0002);
		check({15'h0000, irq}, 16'h0000);
		run_cmd(8'h02, 15'h0100, 4'h8);
		rd_reg(pmsw_pkg::IRQ_STAT_OFS, d);
		check(d & 16'h0002, 16'h0002);
		check({15'h0000, irq}, 16'h0001);
		wr_reg(pmsw_pkg::IRQ_MASK_OFS, 16'h0000);
		rd_reg(pmsw_pkg::IRQ_STAT_OFS, d);
		check(d & 16'h0002, 16'h0002);
		check({15'h0000, irq}, 16'h0000);
		wr_reg(pmsw_pkg::IRQ_MASK_OFS, 16'h0002);
		wr_reg(pmsw_pkg::IRQ_STAT_OFS, 16'h0002);
		rd_reg(pmsw_pkg::IRQ_STAT_OFS, d);
		check(d & 16'h0002, 16'h0000);
		check({15'h0000, irq}, 16'h0000);
		run_cmd(8'h26, 15'h0300, 4'h1);
		rd_reg(pmsw_pkg::IRQ_STAT_OFS, d);
		check(d & 16'h0001, 16'h0001);
		$display("interrupt test done");
	endtask : t_irq

	initial begin
		failures = 0;
		checked = 0;
		cycles = 0;
		reset = 1'b1;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		cfg_word_two = 14'h3fff;
		pm_addr = 15'h0000;
		pm_wdata = 14'h0000;
		flash_rdata = 14'h0000;
		flash_done = 1'b0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_read();
		t_modes();
		t_protect();
		t_irq();
		end_of_test();
	end
endmodule : program_memory_self_write_ctrl_test
